// *** gls_chk_sva.sv ***
// Checker for gls_led_gpio, bound to each instance.
// Assumes one clock and the instance's BLINK_CYC.
`timescale 1ns/10ps
`default_nettype none
module gls_chk #(parameter int unsigned BLINK_CYC = 8) (
    input wire logic sys_clk_i,
    input wire logic rst_b_i,
    input wire gls_pkg::gls_pin_cfg_s [2:0] pin_cfg_i,
    input wire gls_pkg::gls_phy_s phy_i,
    input wire logic [2:0] pad_o,
    input wire logic [2:0] pad_oe_o,
    input wire logic speed_indicator_n_o,
    input wire logic link_activity_indicator_n_o,
    input wire logic duplex_indicator_n_o
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!rst_b_i);
    wire logic led = link_activity_indicator_n_o;
    wire logic [2:0] ind = {duplex_indicator_n_o, led, speed_indicator_n_o};
    wire logic [2:0] role = {pin_cfg_i[2].led_role, pin_cfg_i[1].led_role,
        pin_cfg_i[0].led_role};
    int unsigned run_r;
    logic cut_r;
    // A link drop cuts a blink short, so that stretch is not timed
    always_ff @(posedge sys_clk_i) begin
        run_r <= $changed(led) ? 1 : run_r + 1;
        // A rise caused by the link going down must not start a timed run
        if (!rst_b_i || !phy_i.link_up) begin
            cut_r <= 1'b1;
        end else if ($rose(led) && $past(phy_i.link_up)) begin
            cut_r <= 1'b0;
        end
    end
    a_speed_map: assert property (rst_b_i |=> speed_indicator_n_o ==
        !$past(phy_i.link_up && phy_i.speed_100)) else $error("speed");
    a_duplex_map: assert property (rst_b_i |=> duplex_indicator_n_o ==
        !$past(phy_i.link_up && phy_i.full_duplex)) else $error("duplex");
    a_link_dark: assert property (!phy_i.link_up |=> led)
        else $error("no link lit");
    a_lit_idle: assert property (!led && phy_i.link_up &&
        !phy_i.activity && !$past(phy_i.activity) |=> !led) else $error("lit");
    a_blink_len: assert property ($fell(led) && !cut_r |->
        run_r == BLINK_CYC) else $error("blink");
    a_hold_len: assert property ($rose(led) && !cut_r |->
        run_r >= BLINK_CYC) else $error("hold");
    a_led_drive: assert property (
        1 |-> ((pad_o | (pad_oe_o ^ ~$past(ind))) & $past(role)) == 3'h0)
        else $error("led pin");
    a_gp_push: assert property (
        $past(rst_b_i) && $past(pin_cfg_i[0]) == 4'h3 |-> pad_oe_o[0] &&
        pad_o[0]) else $error("push-pull");
    c_blink: cover property ($fell(led) && !cut_r);
    c_hold: cover property ($rose(led) && !cut_r);
    c_push: cover property (pad_oe_o[0] && pad_o[0]);
    c_link_drop: cover property (phy_i.link_up ##1 !phy_i.link_up);
endmodule : gls_chk
bind gls_led_gpio gls_chk #(.BLINK_CYC(BLINK_CYC)) u_chk (
    .sys_clk_i(sys_clk_i),
    .rst_b_i(rst_b_i),
    .pin_cfg_i(pin_cfg_i),
    .phy_i(phy_i),
    .pad_o(pad_o),
    .pad_oe_o(pad_oe_o),
    .speed_indicator_n_o(speed_indicator_n_o),
    .link_activity_indicator_n_o(link_activity_indicator_n_o),
    .duplex_indicator_n_o(duplex_indicator_n_o)
);
`default_nettype wire

// *** gls_defs.svh ***
// Constants for the shared status/general-purpose pin block.
// Assumes a 200 MHz system clock and plain include by bare name.
// Functional notes
// - Software sets each of the three pins push-pull, open-drain or input.
// - A pin in indicator role is open-drain; push-pull is ignored.
// - The speed indicator is driven low while the link runs at 100Mb.
// - The speed indicator is high in auto-negotiation, no cable or 10Mbs.
// - The link indicator is held low while linked and no blink runs.
// - Transmit or receive activity pulses the link indicator high 80mS.
// - After each off pulse the link indicator stays low at least 80mS.
// - The duplex indicator is low in full duplex and high otherwise.
`ifndef GLS_DEFS_SVH
`define GLS_DEFS_SVH

`define GLS_NUM_PINS 3
`define GLS_CLK_MHZ 200
`define GLS_BLINK_MS 80
// Cycles in one blink phase; 16,000,000 at 200 MHz
`define GLS_BLINK_CYC (`GLS_BLINK_MS * 1000 * `GLS_CLK_MHZ)
`define GLS_CNT_W 24
// Cycles per timebase tick; one millisecond at 200 MHz
`define GLS_TICK_CYC (`GLS_CLK_MHZ * 1000)
`define GLS_PRE_W 18
`define GLS_IND_RESET 1'b1
`define GLS_PIN_SPEED 0
`define GLS_PIN_LINK 1
`define GLS_PIN_DUPLEX 2
`define GLS_DIR_INPUT 2'h0
`define GLS_DIR_PUSH_PULL 2'h1
`define GLS_DIR_OPEN_DRAIN 2'h2

`endif

// *** gls_led_gpio.sv ***
// Top of the three shared status-indicator / general-purpose pins.
// Assumes PHY status and configuration arrive on sys_clk_i; pads are
// resolved outside from pad_o and pad_oe_o.
`timescale 1ns/10ps
`default_nettype none
`include "gls_defs.svh"
module gls_led_gpio #(
    parameter int unsigned BLINK_CYC = `GLS_BLINK_CYC
) (
    input wire logic sys_clk_i,
    input wire logic rst_b_i,
    input wire gls_pkg::gls_pin_cfg_s [`GLS_NUM_PINS-1:0] pin_cfg_i,
    input wire gls_pkg::gls_phy_s phy_i,
    input wire logic [`GLS_NUM_PINS-1:0] pad_i,
    output logic [`GLS_NUM_PINS-1:0] pad_o,
    output logic [`GLS_NUM_PINS-1:0] pad_oe_o,
    output logic [`GLS_NUM_PINS-1:0] gpio_in_o,
    output logic speed_indicator_n_o,
    output logic link_activity_indicator_n_o,
    output logic duplex_indicator_n_o
);
    // Phase timebase: a divider gives a one-cycle tick and the phase
    // counter counts ticks, so the long 80 ms count stays narrow. A phase
    // that is no whole number of ticks falls back to a tick every cycle.
    localparam int unsigned TICK_DIV =
        ((BLINK_CYC % `GLS_TICK_CYC) == 0) ? `GLS_TICK_CYC : 1;
    localparam int unsigned PHASE_TICKS = BLINK_CYC / TICK_DIV;
    localparam logic [`GLS_PRE_W-1:0] PRE_LAST = `GLS_PRE_W'(TICK_DIV - 1);
    localparam logic [`GLS_CNT_W-1:0] CNT_LAST = `GLS_CNT_W'(PHASE_TICKS - 1);

    gls_pkg::gls_blk_e blk_r;
    logic [`GLS_PRE_W-1:0] pre_r;
    logic [`GLS_CNT_W-1:0] cnt_r;
    logic blk_lit;
    logic blk_off;
    logic blk_hold;
    logic timing;
    logic pre_last;
    logic tick;
    logic cnt_last;
    logic phase_done;
    logic act_start;
    logic speed_lit;
    logic duplex_lit;
    logic link_dark;
    logic [`GLS_NUM_PINS-1:0] led_n;

    // State decode, kept apart so the phase logic reads as plain flags
    always_comb begin
        blk_lit = (blk_r == gls_pkg::GLS_BLK_LIT);
        blk_off = (blk_r == gls_pkg::GLS_BLK_OFF);
        blk_hold = (blk_r == gls_pkg::GLS_BLK_HOLD);
    end

    // The timebase only runs inside a blink phase with the link up
    assign timing = phy_i.link_up & (blk_off | blk_hold);
    assign pre_last = (pre_r == PRE_LAST);
    assign tick = timing & pre_last;
    assign cnt_last = (cnt_r == CNT_LAST);
    assign phase_done = tick & cnt_last;

    // Activity is only looked at while lit; pulses seen during a blink
    // are dropped, not queued, so a busy link blinks at a steady rate
    assign act_start = phy_i.link_up & blk_lit & phy_i.activity;

    // Tick divider, restarted at each phase so every phase is exact
    always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            pre_r <= '0;
        end else if (!timing || pre_last) begin
            pre_r <= '0;
        end else begin
            pre_r <= pre_r + 1'b1;
        end
    end

    // Ticks within the current phase
    always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            cnt_r <= '0;
        end else if (!timing || phase_done) begin
            cnt_r <= '0;
        end else if (tick) begin
            cnt_r <= cnt_r + 1'b1;
        end
    end

    // Blink sequencer: lit, off for one phase, held lit for one phase
    always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            blk_r <= gls_pkg::GLS_BLK_LIT;
        end else if (!phy_i.link_up) begin
            // Losing the link abandons any blink in flight
            blk_r <= gls_pkg::GLS_BLK_LIT;
        end else begin
            case (blk_r)
                gls_pkg::GLS_BLK_LIT: begin
                    if (act_start) begin
                        blk_r <= gls_pkg::GLS_BLK_OFF;
                    end
                end
                gls_pkg::GLS_BLK_OFF: begin
                    if (phase_done) begin
                        blk_r <= gls_pkg::GLS_BLK_HOLD;
                    end
                end
                gls_pkg::GLS_BLK_HOLD: begin
                    // A new pulse can only start after returning to lit
                    if (phase_done) begin
                        blk_r <= gls_pkg::GLS_BLK_LIT;
                    end
                end
                default: begin
                    blk_r <= gls_pkg::GLS_BLK_LIT;
                end
            endcase
        end
    end

    // Speed and duplex need a live link, which also covers a missing
    // cable and auto-negotiation still in progress
    assign speed_lit = phy_i.link_up & phy_i.speed_100;
    assign duplex_lit = phy_i.link_up & phy_i.full_duplex;
    assign link_dark = ~phy_i.link_up | blk_off;

    always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            speed_indicator_n_o <= `GLS_IND_RESET;
        end else begin
            speed_indicator_n_o <= ~speed_lit;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            link_activity_indicator_n_o <= `GLS_IND_RESET;
        end else begin
            link_activity_indicator_n_o <= link_dark;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            duplex_indicator_n_o <= `GLS_IND_RESET;
        end else begin
            duplex_indicator_n_o <= ~duplex_lit;
        end
    end

    assign led_n[`GLS_PIN_SPEED] = speed_indicator_n_o;
    assign led_n[`GLS_PIN_LINK] = link_activity_indicator_n_o;
    assign led_n[`GLS_PIN_DUPLEX] = duplex_indicator_n_o;

    genvar gi;
    generate
        for (gi = 0; gi < `GLS_NUM_PINS; gi++) begin : g_pin
            gls_pin_cell u_cell (
                .sys_clk_i(sys_clk_i),
                .rst_b_i(rst_b_i),
                .cfg_i(pin_cfg_i[gi]),
                .led_n_i(led_n[gi]),
                .pad_i(pad_i[gi]),
                .pad_o(pad_o[gi]),
                .pad_oe_o(pad_oe_o[gi]),
                .in_val_o(gpio_in_o[gi])
            );
        end
    endgenerate
endmodule : gls_led_gpio
`default_nettype wire

// *** gls_led_gpio_tb_top.sv ***
// Bench for gls_led_gpio: link table, pin roles, blink, reset.
// Assumes gls_pad_model as the board; blink shortened to B cycles.
`timescale 1ns/10ps
`default_nettype none
module gls_led_gpio_tb_top;
    localparam int B = 8;
    logic sys_clk_i = 0;
    logic rst_b_i = 0;
    logic [11:0] cfg = '0;
    logic [3:0] phy = '0;
    wire logic [2:0] po;
    wire logic [2:0] oe;
    wire logic [2:0] gi;
    wire logic [2:0] pad;
    wire logic [2:0] ind;
    logic [2:0] ee = '0;
    logic [2:0] ev = '0;
    int n_mismatch = 0;
    int cmp_count = 0;
    int k;
    // PHY {link, 100M, full, activity}, then {duplex, link, speed}
    logic [6:0] rows [5] = '{7'h45, 7'h64, 7'h51, 7'h37, 7'h70};
    gls_led_gpio #(.BLINK_CYC(B)) uut (.sys_clk_i(sys_clk_i),
        .rst_b_i(rst_b_i), .pin_cfg_i(cfg), .phy_i(phy), .pad_i(pad),
        .pad_o(po), .pad_oe_o(oe), .gpio_in_o(gi),
        .speed_indicator_n_o(ind[0]), .link_activity_indicator_n_o(ind[1]),
        .duplex_indicator_n_o(ind[2]));
    gls_pad_model brd (.drv_i(po), .drv_en_i(oe), .ext_en_i(ee),
        .ext_i(ev), .pad_o(pad));
    initial forever #2.5 sys_clk_i = ~sys_clk_i;
    task chk(input logic [11:0] g, input logic [11:0] e);
        cmp_count++;
        if (g !== e) begin
            $display("BAD t=%0t got %h exp %h", $time, g, e);
            n_mismatch++;
        end
    endtask : chk
    task step(input int n);
        repeat (n) @(posedge sys_clk_i);
        #1;
    endtask : step
    // Counts samples while the link LED holds v; a stuck LED ends the run
    task run(input logic v);
        k = 0;
        while (ind[1] === v) begin
            step(1);
            k++;
            if (k > 99) begin
                n_mismatch++;
                finish_test;
            end
        end
    endtask : run
    task pin(input logic [11:0] c, input logic [3:0] p,
        input logic [2:0] e, input logic [2:0] v, input logic [11:0] x);
        @(posedge sys_clk_i) begin
            cfg <= c;
            phy <= p;
            ee <= e;
            ev <= v;
        end
        step(5);
        chk({3'h0, oe, pad, gi}, x);
    endtask : pin
    task finish_test;
        $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : finish_test
    initial begin
        repeat (4) @(posedge sys_clk_i);
        rst_b_i <= 1'b1;
        foreach (rows[i]) begin
            @(posedge sys_clk_i) phy <= rows[i][6:3];
            step(3);
            chk({9'h0, ind}, {9'h0, rows[i][2:0]});
        end
        $display("table done");
        pin(12'hBBB, 4'hE, 3'h0, 3'h0, 12'h1C0);
        pin(12'hB3B, 4'hE, 3'h0, 3'h0, 12'h1D2);
        pin(12'hB3B, 4'h0, 3'h0, 3'h0, 12'h0BF);
        pin(12'h053, 4'h0, 3'h4, 3'h0, 12'h05B);
        pin(12'h042, 4'h0, 3'h4, 3'h4, 12'h0E4);
        $display("pins done");
        pin(12'h042, 4'h8, 3'h4, 3'h4, 12'h0E4);
        @(posedge sys_clk_i) phy <= 4'h9;
        run(1'b0);
        run(1'b1);
        chk(12'(k), 12'(B));
        run(1'b0);
        chk({11'h0, k >= B}, 12'h001);
        $display("blink done");
        // Reset must win over a PHY that asks for every indicator lit
        @(posedge sys_clk_i) begin
            rst_b_i <= 1'b0;
            phy <= 4'hE;
        end
        step(2);
        chk({po, oe, ind, gi}, 12'h038);
        $display("reset done");
        @(posedge sys_clk_i) rst_b_i <= 1'b1;
        step(3);
        chk({po, oe, ind, gi}, 12'h0C4);
        $display("release done");
        finish_test;
    end
endmodule : gls_led_gpio_tb_top
`default_nettype wire

// *** gls_pad_model.sv ***
// Board side of the three pins: LEDs or drivers with pull-ups.
// Assumes the block's drive wins over any board driver.
`timescale 1ns/10ps
`default_nettype none
module gls_pad_model (
    input wire logic [2:0] drv_i,
    input wire logic [2:0] drv_en_i,
    input wire logic [2:0] ext_en_i,
    input wire logic [2:0] ext_i,
    output logic [2:0] pad_o
);
    // A released pin rises to its pull-up instead of keeping its last level
    assign pad_o = (drv_en_i & drv_i) | (~drv_en_i & (~ext_en_i | ext_i));
endmodule : gls_pad_model
`default_nettype wire

// *** gls_pin_cell.sv ***
// One shared pin: chooses general-purpose or indicator drive.
// Assumes cfg and indicator level are on sys_clk_i; pad input is async.
`timescale 1ns/10ps
`default_nettype none
`include "gls_defs.svh"
module gls_pin_cell (
    input wire logic sys_clk_i,
    input wire logic rst_b_i,
    input wire gls_pkg::gls_pin_cfg_s cfg_i,
    input wire logic led_n_i,
    input wire logic pad_i,
    output logic pad_o,
    output logic pad_oe_o,
    output logic in_val_o
);
    logic sync1_r;
    logic sync2_r;

    // Two stages; only the second is read
    always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            sync1_r <= 1'b0;
            sync2_r <= 1'b0;
        end else begin
            sync1_r <= pad_i;
            sync2_r <= sync1_r;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            pad_o <= 1'b0;
            pad_oe_o <= 1'b0;
        end else if (cfg_i.led_role) begin
            // Open drain: drive only the low level
            pad_o <= 1'b0;
            pad_oe_o <= ~led_n_i;
        end else begin
            case (cfg_i.dir)
                `GLS_DIR_PUSH_PULL: begin
                    pad_o <= cfg_i.out_val;
                    pad_oe_o <= 1'b1;
                end
                `GLS_DIR_OPEN_DRAIN: begin
                    pad_o <= 1'b0;
                    pad_oe_o <= ~cfg_i.out_val;
                end
                default: begin
                    pad_o <= 1'b0;
                    pad_oe_o <= 1'b0;
                end
            endcase
        end
    end

    assign in_val_o = sync2_r;
endmodule : gls_pin_cell
`default_nettype wire

// *** gls_pkg.sv ***
// Types for the shared status/general-purpose pin block.
// Assumes gls_defs.svh is on the include path.
`default_nettype none
`include "gls_defs.svh"
package gls_pkg;
    typedef logic [1:0] gls_dir_t;

    // Per-pin configuration as held by the host-side configuration register
    typedef struct packed {
        logic led_role;
        gls_dir_t dir;
        logic out_val;
    } gls_pin_cfg_s;

    // Link status from the integrated PHY
    typedef struct packed {
        logic link_up;
        logic speed_100;
        logic full_duplex;
        logic activity;
    } gls_phy_s;

    typedef enum logic [2:0] {
        GLS_BLK_LIT = 3'h1,
        GLS_BLK_OFF = 3'h2,
        GLS_BLK_HOLD = 3'h4
    } gls_blk_e;
endpackage : gls_pkg
`default_nettype wire
